// ### src/data_move_instruction_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - Copy pattern reads selected file register
// RULE2 - Dest bit 0 accumulator, 1 file register
// RULE3 - Copy updates zero flag only
// RULE4 - Dest 1 rewrites same value, tests zero
// RULE5 - Load immediate to accumulator, flags kept
// RULE6 - Store accumulator to file register
// RULE7 - Nop idles; setup word loads timer setup
module data_move_instruction_exec
  import data_move_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire logic                              insn_valid,
  input  wire logic [data_move_pkg::INSN_W-1:0]  insn,
  output logic                                   insn_ready,
  output logic      [data_move_pkg::DATA_W-1:0]  acc,
  output logic                                   zero_flag,
  output logic      [data_move_pkg::DATA_W-1:0]  timer_setup,
  output logic                                   busy
);
  // Sequencer states; the usual path flips one bit
  typedef enum logic [1:0] {
    ST_DECODE = 2'b00,
    ST_READ   = 2'b01
  } state_t;

  // Classify one instruction word.
  // Whole-word matches go first: no other mask covers them
  // today, but keeping them ahead means a wider mask added
  // later cannot swallow the no-op or the setup word.
  function automatic op_t decode_op(input logic [INSN_W-1:0] w);
    op_t r;
    r = OP_OTHER;
    if (w == NOP_WORD) begin
      r = OP_NOP;
    end else if (w == TSETUP_WORD) begin
      r = OP_TSETUP;
    end else if ((w & COPY_MASK) == COPY_MATCH) begin
      r = OP_COPY;
    end else if ((w & LDI_MASK) == LDI_MATCH) begin
      r = OP_LDI;
    end else if ((w & STA_MASK) == STA_MATCH) begin
      r = OP_STA;
    end
    return r;
  endfunction : decode_op

  // File index in the low operand bits of a word;
  // shared by the read port, the copy latch and the store
  function automatic logic [FIDX_W-1:0] operand_idx(input logic [INSN_W-1:0] w);
    return w[FIDX_W-1:0];
  endfunction : operand_idx

  // Literal carried in the low byte of a load word
  function automatic logic [DATA_W-1:0] literal_of(input logic [INSN_W-1:0] w);
    return w[DATA_W-1:0];
  endfunction : literal_of

  // Sequencer group: where we are, and what a copy remembers
  state_t            state_ff, nxt_state;
  logic [FIDX_W-1:0] idx_ff, nxt_idx;
  logic              dest_ff, nxt_dest;

  // Accumulator and zero flag group
  logic [DATA_W-1:0] acc_ff, nxt_acc;
  logic              zero_ff, nxt_zero;

  // Timer setup group
  logic [DATA_W-1:0] tsetup_ff, nxt_tsetup;

  // File storage ports
  logic [FIDX_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              wr_en;
  logic [FIDX_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;

  // Decode strobes, one per instruction that does work
  op_t               op;
  logic              take;
  logic              take_copy;
  logic              take_ldi;
  logic              take_sta;
  logic              take_tsetup;
  logic              read_cycle;
  logic              read_zero;

  // Classify whatever stands on the bus; it only counts when taken
  assign op          = decode_op(insn);

  // A word is taken only while decoding; in the read cycle
  // the word on the bus is left alone and offered again.
  // RULE7 no-op taken, no strobe
  // Unknown words are consumed the same way, with no effect
  assign take        = insn_valid && (state_ff == ST_DECODE);

  // RULE1 copy pattern taken
  assign take_copy   = take && (op == OP_COPY);

  // RULE5 load pattern taken
  assign take_ldi    = take && (op == OP_LDI);

  // RULE6 store pattern taken
  assign take_sta    = take && (op == OP_STA);

  // RULE7 setup word taken
  assign take_tsetup = take && (op == OP_TSETUP);

  // Second cycle of a copy, when the read data stand
  assign read_cycle  = (state_ff == ST_READ);

  // RULE3 zero test on moved value
  assign read_zero   = (rd_data == '0);

  // RULE1 read port addressed from the word
  // The read is registered, so the value stands one edge after
  // the copy is taken; that is why a copy costs two cycles.
  // Storage has no reset: a copy of an index never stored
  // returns unknown data, a limitation the user must respect.
  assign rd_addr     = operand_idx(insn);

  file_regs u_regs (
    .clk     (clk),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data)
  );

  // Sequencer next state; a copy parks in the read cycle once
  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_dest  = dest_ff;
    unique case (state_ff)
      ST_DECODE: begin
        // RULE1 latch file index
        if (take_copy) begin
          nxt_idx   = operand_idx(insn);
          // RULE2 latch target select
          nxt_dest  = insn[DEST_BIT];
          nxt_state = ST_READ;
        end
      end
      ST_READ: begin
        nxt_state = ST_DECODE;
      end
      // Unused codes fall back to decode
      default: begin
        nxt_state = ST_DECODE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_DECODE;
      idx_ff   <= '0;
      dest_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      dest_ff  <= nxt_dest;
    end
  end

  // Accumulator and zero flag next values.
  // A load and a copy result never meet: the load needs the
  // decode state and the copy result lands in the read cycle.
  always_comb begin
    nxt_acc  = acc_ff;
    nxt_zero = zero_ff;
    // RULE5 literal load, flag kept
    if (take_ldi) begin
      nxt_acc = literal_of(insn);
    end
    if (read_cycle) begin
      // RULE3 zero flag only
      nxt_zero = read_zero;
      // RULE2 target select 0, accumulator
      if (!dest_ff) begin
        nxt_acc = rd_data;
      end
    end
  end

  // Accumulator and zero flag registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff  <= ACC_RST;
      zero_ff <= ZERO_RST;
    end else begin
      acc_ff  <= nxt_acc;
      zero_ff <= nxt_zero;
    end
  end

  // Timer setup next value; holds its reset value until loaded
  always_comb begin
    nxt_tsetup = tsetup_ff;
    // RULE7 setup takes accumulator
    if (take_tsetup) begin
      nxt_tsetup = acc_ff;
    end
  end

  // Timer setup register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tsetup_ff <= TSETUP_RST;
    end else begin
      tsetup_ff <= nxt_tsetup;
    end
  end

  // File write port. Store and write-back never collide,
  // because new words are refused in the read cycle.
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = idx_ff;
    wr_data = acc_ff;
    if (take_sta) begin
      // RULE6 store accumulator
      wr_en   = 1'b1;
      wr_addr = operand_idx(insn);
      wr_data = acc_ff;
    end else if (read_cycle && dest_ff) begin
      // RULE4 same value written back
      // Writing it back keeps one write path for both targets
      wr_en   = 1'b1;
      wr_addr = idx_ff;
      wr_data = rd_data;
    end
  end

  // Handshake from the state register alone; data from flops
  assign insn_ready  = (state_ff == ST_DECODE);
  assign busy        = read_cycle;
  assign acc         = acc_ff;
  assign zero_flag   = zero_ff;
  assign timer_setup = tsetup_ff;
endmodule : data_move_instruction_exec
`default_nettype wire

// ### src/data_move_pkg.sv
package data_move_pkg;

  // Instruction word and data widths
  localparam int unsigned INSN_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIDX_W = 5;
  localparam int unsigned NREGS  = 32;

  // Opcode masks and match values
  localparam logic [11:0] COPY_MASK  = 12'hFC0;
  localparam logic [11:0] COPY_MATCH = 12'h200;
  localparam logic [11:0] LDI_MASK   = 12'hF00;
  localparam logic [11:0] LDI_MATCH  = 12'hC00;
  localparam logic [11:0] STA_MASK   = 12'hFE0;
  localparam logic [11:0] STA_MATCH  = 12'h020;
  localparam logic [11:0] NOP_WORD   = 12'h000;
  localparam logic [11:0] TSETUP_WORD = 12'h002;

  // Field positions
  localparam int unsigned DEST_BIT = 5;

  // Reset values
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [7:0] TSETUP_RST = 8'hFF;
  localparam logic       ZERO_RST   = 1'b0;

  typedef enum logic [2:0] {
    OP_NOP    = 3'h0,
    OP_COPY   = 3'h1,
    OP_LDI    = 3'h2,
    OP_STA    = 3'h3,
    OP_TSETUP = 3'h4,
    OP_OTHER  = 3'h5
  } op_t;

endpackage : data_move_pkg

// ### src/file_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Small register file, registered read port
module file_regs
  import data_move_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic [data_move_pkg::FIDX_W-1:0] rd_addr,
  output logic      [data_move_pkg::DATA_W-1:0] rd_data,
  input  wire logic                     wr_en,
  input  wire logic [data_move_pkg::FIDX_W-1:0] wr_addr,
  input  wire logic [data_move_pkg::DATA_W-1:0] wr_data
);
  logic [DATA_W-1:0] mem_ff [NREGS];

  // No reset on storage; contents undefined until written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
    rd_data <= mem_ff[rd_addr];
  end
endmodule : file_regs
`default_nettype wire

// ### test/dm_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dm_chk
  import data_move_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        insn_valid,
  input  wire logic        insn_ready,
  input  wire logic        zero_flag,
  input  wire logic        busy,
  input  wire logic [11:0] insn,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  timer_setup
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Decoded takes; literal split out for a plain past value
  wire tk = insn_valid && insn_ready;
  wire cp = tk && (insn & COPY_MASK) == COPY_MATCH;
  wire [7:0] lit = insn[7:0];
  chk_copy_stall: assert property (cp |=> busy && !insn_ready ##1 !busy)
    else $error("stall");
  chk_copy_zero: assert property (cp && !insn[5] |=> ##1 zero_flag == (acc == 8'h00))
    else $error("zero");
  chk_test_keep: assert property (cp && insn[5] |=> $stable(acc) [*2])
    else $error("test");
  chk_load_lit: assert property (tk && (insn & LDI_MASK) == LDI_MATCH |=> acc == $past(lit))
    else $error("load");
  chk_store_keep: assert property (tk && (insn & STA_MASK) == STA_MATCH |=> $stable({acc, zero_flag}))
    else $error("store");
  chk_setup_load: assert property (tk && insn == TSETUP_WORD |=> timer_setup == $past(acc))
    else $error("setup");
  chk_zero_cause: assert property ($changed(zero_flag) |-> $past(busy))
    else $error("cause");
endmodule : dm_chk
bind data_move_instruction_exec dm_chk u_chk (.clk, .arst_n, .insn_valid, .insn_ready, .zero_flag, .busy,
  .insn, .acc, .timer_setup);
`default_nettype wire

// ### test/prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module prog_mem (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        slow,
  input  wire logic        insn_ready,
  output logic             insn_valid,
  output logic      [11:0] insn
);
  logic [11:0] rom [64];
  logic [6:0] pc;
  logic hold_ff;
  // A word once offered stays up until taken
  assign insn_valid = arst_n && !pc[6] && (hold_ff || !slow);
  // Idle bus shows the inverse, never a stale word
  assign insn = insn_valid ? rom[pc[5:0]] : ~rom[pc[5:0]];
  always @(posedge clk or negedge arst_n)
    if (!arst_n) {pc, hold_ff} <= 8'h00;
    else begin
      hold_ff <= insn_valid && !insn_ready;
      pc <= pc + 7'(insn_valid && insn_ready);
    end
endmodule : prog_mem
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import data_move_pkg::*;
  logic clk = 0, arst_n = 0, slow = 0, pend, rz;
  wire insn_valid, insn_ready, zero_flag, busy;
  wire [11:0] insn;
  wire [7:0] acc, timer_setup;
  logic [7:0] ra, rt, rr [4];
  logic [11:0] pw, cw [12] = '{12'hC00, 12'h020, 12'h021, 12'h022, 12'h023, 12'h223,
    12'hC5A, 12'h002, 12'h200, 12'h020, 12'h000, 12'hF00};
  logic [15:0] r = 16'h68A0;
  int err_total, checks, i;
  data_move_instruction_exec u_dut (.clk, .arst_n, .insn_valid, .insn, .insn_ready, .acc, .zero_flag,
    .timer_setup, .busy);
  prog_mem u_mem (.clk, .arst_n, .slow, .insn_ready, .insn_valid, .insn);
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], ^(v & 16'hB400)};
  endfunction : lfsr
  // Pattern match for the reference
  function automatic logic hits(logic [11:0] w, m, v);
    return (w & m) == v;
  endfunction : hits
  task automatic chk(logic [18:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value state exp %h seen %h", exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("err_total %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial forever #25 clk = ~clk;
  // Reference; a copy lands one edge late and blocks intake meanwhile
  wire tk = insn_valid && !pend;
  always @(posedge clk or negedge arst_n)
    if (!arst_n) {ra, rz, rt, pend} <= 18'h001FE;
    else begin
      pend <= tk && hits(insn, COPY_MASK, COPY_MATCH);
      pw <= insn;
      if (pend) rz <= rr[pw[1:0]] == 8'h00;
      if (pend && !pw[5]) ra <= rr[pw[1:0]];
      if (tk && hits(insn, LDI_MASK, LDI_MATCH)) ra <= insn[7:0];
      if (tk && hits(insn, STA_MASK, STA_MATCH)) rr[insn[1:0]] <= ra;
      if (tk && insn == TSETUP_WORD) rt <= ra;
    end
  always @(negedge clk) if (arst_n) begin
    chk({acc, zero_flag, timer_setup, insn_ready, busy}, {ra, rz, rt, !pend, pend});
  end
  // Corners first, then random literals and table words
  initial begin
    for (i = 0; i < 64; i++) begin
      r = lfsr(r);
      u_mem.rom[i] = i < 12 ? cw[i] : r[3] ? {4'hC, r[15:8]} : cw[4'(r[2:0]) + 4'h4];
    end
    repeat (16) @(posedge clk);
    #5 arst_n = 1;
    for (i = 0; i < 600 && !u_mem.pc[6]; i++) begin
      @(posedge clk);
      #5 r = lfsr(r);
      slow = r[3];
    end
    if (!u_mem.pc[6]) chk(19'h00000, 19'h00001);
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule : testbench
`default_nettype wire
